// ==== irport_pkg.sv ====
package irport_pkg;
	// ****************************************
	// Register offsets (byte address = 4 * index)
	// ****************************************
	localparam logic [2:0] REG_DIV_LOW = 3'h0;
	localparam logic [2:0] REG_DIV_HIGH = 3'h1;
	localparam logic [2:0] REG_CTRL_ONE = 3'h2;
	localparam logic [2:0] REG_BANK_SEL = 3'h3;
	localparam logic [2:0] REG_HANDSHAKE = 3'h4;
	localparam logic [2:0] REG_LINE_STATUS = 3'h5;
	localparam logic [2:0] REG_DEPTH_TX = 3'h6;
	localparam logic [2:0] REG_USER_STATUS = 3'h7;
	localparam logic [2:0] REG_EVENTS = 3'h6;
	// ****************************************
	// Bank select codes
	// ****************************************
	localparam logic [7:0] SEL_BANK2 = 8'hE0;
	localparam logic [7:0] SEL_BANK3 = 8'hE4;
	localparam logic [7:0] SEL_BANK4 = 8'hE8;
	localparam logic [7:0] SEL_BANK5 = 8'hEC;
	localparam logic [7:0] SEL_BANK6 = 8'hF0;
	localparam logic [7:0] SEL_BANK7 = 8'hF4;
	localparam logic [7:0] SEL_RESET = 8'hE0;
	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [7:0] HANDSHAKE_RESET = 8'h60;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam int MODE_LSB = 5;
	localparam int B_PULSE = 4;
	localparam int B_LOOP = 4;
	localparam int B_IRQ_EN = 3;
	localparam int B_TX_WAIT = 3;
	localparam int B_DMA_EN = 2;
	localparam int B_BAUD_OUT = 7;
	localparam int B_LOOP_OUT = 5;
	localparam int B_ALL_LOOP = 4;
	localparam int B_CH_SWAP = 3;
	localparam int B_DMA_THR = 2;
	localparam int B_ADV_SEL = 0;
	localparam int B_FALLBACK_DIS = 7;
	// ****************************************
	// Modes and thresholds
	// ****************************************
	typedef enum logic [2:0] {
		MODE_RSVD0 = 3'b000,
		MODE_MIR_LOW = 3'b001,
		MODE_ASK = 3'b010,
		MODE_SIR = 3'b011,
		MODE_MIR_HIGH = 3'b100,
		MODE_FIR = 3'b101,
		MODE_CIR = 3'b110,
		MODE_RSVD7 = 3'b111
	} adv_mode_t;
	localparam logic [5:0] TX_THR_LOW = 6'h0D;
	localparam logic [5:0] TX_THR_HIGH16 = 6'h17;
	localparam logic [5:0] TX_THR_HIGH32 = 6'h07;
	localparam logic [5:0] RX_THR_LOW = 6'h04;
	localparam logic [5:0] RX_THR_HIGH = 6'h0A;
	localparam int CLK_MHZ = 250;
	localparam int PULSE_MS = 2;
	localparam int PULSE_CYCLES = PULSE_MS * 1000 * 1000 * CLK_MHZ / 1000;
endpackage : irport_pkg

// ==== ir_pulse_timer.sv ====
`timescale 1ns/1ns
module ir_pulse_timer #(
	parameter int CYCLES = 500000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic busy
);
	logic [19:0] count_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= 20'h00000;
		end else if (start && count_q == 20'h00000) begin
			count_q <= 20'(CYCLES);
		end else if (count_q != 20'h00000) begin
			count_q <= count_q - 20'h00001;
		end
	end
	assign busy = (count_q != 20'h00000);
endmodule : ir_pulse_timer

// ==== irport_ctrl.sv ====
`timescale 1ns/1ns
// What this block does
// - Select writes choose bank from code
// - Legacy loopback forces transmit low unless loop output bit is set, isolates receive
// - Legacy interrupt output gated by enable bit
// - Advanced mode field selects link mode
// - Fallback clears mode field, returns legacy
// - Pulse request sends 2 ms pulse, self-clears
// - Transmit wait holds until threshold or timeout
// - Single DMA channel direction set by swap
// - Last byte of frame flag at output
// - Length exceeded sets flag, stops storing
// - Symbol error sets flag, aborts, ends frame
// - CRC failure sets CRC error flag
// - Flow switch sets flag, read clears
// - Underrun on empty without end, write-one clears
// - Lost end or remote pulse, read clears
// - Frame end request acts as terminal count
// - Frame ends pending while markers stored
// - Receive timeout from either FIFO
// - Legacy divisor access in advanced forces fallback
// - Baud clock output drives DTR pin
// - All mode loopback, optional output to pin
// - DMA threshold bit picks thresholds
module irport_ctrl (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TX_DATA,
	input wire logic TX_EMPTY,
	input wire logic TX_FIFO_LEVEL_OK,
	input wire logic TX_TIMEOUT,
	input wire logic DMA_TC,
	input wire logic [5:0] TX_DEPTH,
	input wire logic [5:0] RX_DEPTH,
	input wire logic FIFO_32,
	input wire logic RX_FRAME_LAST,
	input wire logic RX_LEN_OVER,
	input wire logic RX_BAD_SYMBOL,
	input wire logic RX_CRC_BAD,
	input wire logic RX_END_LOST,
	input wire logic RX_REMOTE_PULSE,
	input wire logic RX_MARKERS_STORED,
	input wire logic RX_DATA_TIMEOUT,
	input wire logic RX_STATUS_TIMEOUT,
	input wire logic FLOW_SWITCH,
	input wire logic RX_BUSY,
	input wire logic BAUD_CLK,
	input wire logic UART_IRQ,
	input wire logic IR_RX_PIN,
	input wire logic DTR_BIT,
	output logic IR_TX_PIN,
	output logic DTR_PIN,
	output logic IRQ_OUT,
	output logic RX_LINE,
	output logic LOOPBACK,
	output logic TX_GO,
	output logic RX_STORE_EN,
	output logic RX_ABORT,
	output logic FRAME_END,
	output logic TX_TERM_COUNT,
	output logic DMA_ENABLE,
	output logic DMA_SERVES_TX,
	output logic [5:0] TX_THRESHOLD,
	output logic [5:0] RX_THRESHOLD,
	output logic [15:0] DIVISOR,
	output logic ADVANCED,
	output logic [2:0] MODE
);
	import irport_pkg::*;

	// ****************************************
	// Bus access
	// ****************************************
	logic [2:0] bank_q;
	logic [7:0] handshake_q;
	logic [7:0] ctrl_one_q;
	logic [7:0] ctrl_two_q;
	logic [7:0] scratch_q;
	logic [15:0] div_q;
	logic [15:0] adv_div_q;
	logic [7:0] status_q;
	logic [7:0] user_q;
	logic [1:0] rx_sync_q;
	logic [2:0] reg_idx;
	logic wr;
	logic rd;
	logic fast_mode;
	logic fallback;
	logic pulse_busy;
	logic loop_active;
	logic [7:0] wbyte;
	logic [7:0] rdata;
	adv_mode_t mode;

	assign reg_idx = PADDR[4:2];
	assign wbyte = PWDATA[7:0];
	assign wr = PSEL && PENABLE && PWRITE;
	// Read-clear on the capture edge, so no event slips in between
	assign rd = PSEL && !PENABLE && !PWRITE;
	// Every access completes at once, so no wait states
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign mode = adv_mode_t'(handshake_q[MODE_LSB +: 3]);
	assign fast_mode = ctrl_one_q[B_ADV_SEL] && (mode == MODE_MIR_LOW ||
		mode == MODE_MIR_HIGH || mode == MODE_FIR);

	// ****************************************
	// Bank selection
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			bank_q <= 3'd2;
		end else if (wr && reg_idx == REG_BANK_SEL) begin
			if (!wbyte[7]) begin
				bank_q <= 3'd0;
			end else if (wbyte == SEL_BANK2) begin
				bank_q <= 3'd2;
			end else if (wbyte == SEL_BANK3) begin
				bank_q <= 3'd3;
			end else if (wbyte == SEL_BANK4) begin
				bank_q <= 3'd4;
			end else if (wbyte == SEL_BANK5) begin
				bank_q <= 3'd5;
			end else if (wbyte == SEL_BANK6) begin
				bank_q <= 3'd6;
			end else if (wbyte == SEL_BANK7) begin
				bank_q <= 3'd7;
			end else begin
				bank_q <= 3'd1;
			end
		end
	end

	// Legacy divisor touched in advanced mode triggers fallback
	assign fallback = PSEL && PENABLE && bank_q == 3'd1 && ctrl_one_q[B_ADV_SEL] &&
		!ctrl_two_q[B_FALLBACK_DIS] && (reg_idx == REG_DIV_LOW ||
		reg_idx == REG_DIV_HIGH);

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			handshake_q <= HANDSHAKE_RESET;
		end else begin
			if (wr && reg_idx == REG_HANDSHAKE && bank_q <= 3'd1) begin
				handshake_q <= wbyte;
			end else if (handshake_q[B_PULSE] && fast_mode && pulse_busy) begin
				handshake_q[B_PULSE] <= 1'b0;
			end
			if (fallback) begin
				handshake_q[7:5] <= 3'b000;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			ctrl_one_q <= CTRL_ONE_RESET;
			ctrl_two_q <= 8'h00;
		end else if (fallback) begin
			ctrl_one_q[0] <= 1'b0;
			ctrl_one_q[5] <= 1'b0;
			ctrl_one_q[7] <= 1'b0;
		end else if (wr && bank_q == 3'd2 && reg_idx == REG_CTRL_ONE) begin
			ctrl_one_q <= {wbyte[7], 1'b0, wbyte[5:0]};
		end else if (wr && bank_q == 3'd2 && reg_idx == REG_HANDSHAKE) begin
			ctrl_two_q <= {wbyte[7], 1'b0, wbyte[5:0]};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			div_q <= 16'h0001;
			adv_div_q <= 16'h0001;
			scratch_q <= 8'h00;
		end else if (wr) begin
			if (bank_q == 3'd1 && reg_idx == REG_DIV_LOW) begin
				div_q[7:0] <= wbyte;
			end else if (bank_q == 3'd1 && reg_idx == REG_DIV_HIGH) begin
				div_q[15:8] <= wbyte;
			end else if (bank_q == 3'd2 && reg_idx == REG_DIV_LOW) begin
				adv_div_q[7:0] <= wbyte;
			end else if (bank_q == 3'd2 && reg_idx == REG_DIV_HIGH) begin
				adv_div_q[15:8] <= wbyte;
			end else if (bank_q <= 3'd1 && reg_idx == REG_USER_STATUS &&
				!ctrl_one_q[B_ADV_SEL]) begin
				scratch_q <= wbyte;
			end
		end
	end

	// ****************************************
	// Pulse timer
	// ****************************************
	ir_pulse_timer #(
		.CYCLES(PULSE_CYCLES)
	) ir_pulse_timer_i (
		.clk(SYS_CLK),
		.rst(RESET),
		.start(handshake_q[B_PULSE] && fast_mode && !TX_DATA && TX_EMPTY),
		.busy(pulse_busy)
	);

	// ****************************************
	// Status flags (set wins over clear)
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			status_q <= 8'h00;
		end else begin
			status_q[7] <= fast_mode && RX_FRAME_LAST;
			status_q[4] <= (status_q[4] && !(rd && bank_q <= 3'd1 &&
				reg_idx == REG_LINE_STATUS)) || (fast_mode && RX_LEN_OVER);
			status_q[3] <= (status_q[3] && !(rd && bank_q <= 3'd1 &&
				reg_idx == REG_LINE_STATUS)) || (fast_mode && RX_BAD_SYMBOL);
			status_q[2] <= (status_q[2] && !(rd && bank_q <= 3'd1 &&
				reg_idx == REG_LINE_STATUS)) || (fast_mode && RX_CRC_BAD);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			user_q <= 8'h00;
		end else begin
			user_q[7] <= FLOW_SWITCH || (user_q[7] && !(rd && bank_q <= 3'd1 &&
				reg_idx == REG_USER_STATUS));
			user_q[6] <= (fast_mode && TX_EMPTY && !(DMA_ENABLE ? DMA_TC : user_q[3])) ||
				(user_q[6] && !(wr && bank_q <= 3'd1 && reg_idx == REG_USER_STATUS &&
				wbyte[6]));
			user_q[4] <= (fast_mode && RX_END_LOST) ||
				(mode == MODE_CIR && ctrl_one_q[B_ADV_SEL] && RX_REMOTE_PULSE) ||
				(user_q[4] && !(rd && bank_q <= 3'd1 &&
				reg_idx == REG_USER_STATUS));
			if (wr && bank_q <= 3'd1 && reg_idx == REG_USER_STATUS && ctrl_one_q[B_ADV_SEL]) begin
				user_q[3] <= wbyte[3];
			end else if (TX_EMPTY) begin
				user_q[3] <= 1'b0;
			end
			user_q[1] <= RX_MARKERS_STORED;
			user_q[0] <= RX_DATA_TIMEOUT || RX_STATUS_TIMEOUT;
		end
	end

	// ****************************************
	// Receive pin sync and link side
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			rx_sync_q <= 2'b11;
		end else begin
			rx_sync_q <= {rx_sync_q[0], IR_RX_PIN};
		end
	end

	assign loop_active = ctrl_one_q[B_ALL_LOOP] ||
		(!ctrl_one_q[B_ADV_SEL] && handshake_q[B_LOOP]);
	assign LOOPBACK = loop_active;
	// Looped: receive line follows transmit data, pin ignored
	assign RX_LINE = loop_active ? TX_DATA : rx_sync_q[1];

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			IR_TX_PIN <= 1'b0;
			DTR_PIN <= 1'b0;
			IRQ_OUT <= 1'b0;
		end else begin
			if (pulse_busy) begin
				IR_TX_PIN <= 1'b1;
			end else if (loop_active) begin
				IR_TX_PIN <= ctrl_one_q[B_LOOP_OUT] && TX_DATA;
			end else begin
				IR_TX_PIN <= TX_DATA;
			end
			// Divisor test only; normal DTR lost meanwhile
			DTR_PIN <= ctrl_one_q[B_BAUD_OUT] ? BAUD_CLK : DTR_BIT;
			IRQ_OUT <= ctrl_one_q[B_ADV_SEL] ? UART_IRQ :
				(handshake_q[B_IRQ_EN] && UART_IRQ);
		end
	end

	// ****************************************
	// Transmit, receive and DMA control
	// ****************************************
	assign ADVANCED = ctrl_one_q[B_ADV_SEL];
	assign MODE = ctrl_one_q[B_ADV_SEL] ? handshake_q[7:5] : 3'b000;
	assign TX_GO = !(fast_mode && handshake_q[B_TX_WAIT]) ||
		TX_FIFO_LEVEL_OK || TX_TIMEOUT;
	assign RX_STORE_EN = !(fast_mode && (status_q[4] || RX_LEN_OVER));
	assign RX_ABORT = fast_mode && RX_BAD_SYMBOL;
	assign FRAME_END = fast_mode && RX_BAD_SYMBOL;
	assign TX_TERM_COUNT = user_q[3] && !DMA_ENABLE;
	assign DMA_ENABLE = fast_mode && handshake_q[B_DMA_EN];
	assign DMA_SERVES_TX = ctrl_one_q[B_CH_SWAP];
	assign TX_THRESHOLD = !ctrl_one_q[B_DMA_THR] ? TX_THR_LOW :
		(FIFO_32 ? TX_THR_HIGH32 : TX_THR_HIGH16);
	assign RX_THRESHOLD = ctrl_one_q[B_DMA_THR] ? RX_THR_HIGH : RX_THR_LOW;
	assign DIVISOR = ctrl_one_q[B_ADV_SEL] ? adv_div_q : div_q;

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rdata = 8'h00;
		if (reg_idx == REG_BANK_SEL) begin
			rdata = (bank_q >= 3'd2) ? (SEL_RESET + {3'b000, bank_q - 3'd2, 2'b00}) : 8'h00;
		end else if (bank_q <= 3'd1 && reg_idx == REG_HANDSHAKE) begin
			rdata = handshake_q;
		end else if (bank_q <= 3'd1 && reg_idx == REG_LINE_STATUS) begin
			rdata = status_q;
		end else if (bank_q <= 3'd1 && reg_idx == REG_USER_STATUS) begin
			rdata = ctrl_one_q[B_ADV_SEL] ? {user_q[7:6], RX_BUSY, user_q[4:0]} : scratch_q;
		end else if (bank_q == 3'd1 && reg_idx == REG_DIV_LOW) begin
			rdata = div_q[7:0];
		end else if (bank_q == 3'd1 && reg_idx == REG_DIV_HIGH) begin
			rdata = div_q[15:8];
		end else if (bank_q == 3'd2 && reg_idx == REG_DIV_LOW) begin
			rdata = adv_div_q[7:0];
		end else if (bank_q == 3'd2 && reg_idx == REG_DIV_HIGH) begin
			rdata = adv_div_q[15:8];
		end else if (bank_q == 3'd2 && reg_idx == REG_CTRL_ONE) begin
			rdata = ctrl_one_q;
		end else if (bank_q == 3'd2 && reg_idx == REG_HANDSHAKE) begin
			rdata = ctrl_two_q;
		end else if (bank_q == 3'd2 && reg_idx == REG_DEPTH_TX) begin
			rdata = {2'b00, TX_DEPTH};
		end else if (bank_q == 3'd2 && reg_idx == REG_USER_STATUS) begin
			rdata = {2'b00, RX_DEPTH};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= {24'h000000, rdata};
		end
	end
endmodule : irport_ctrl

// ==== irport_ctrl_checker.sv ====
`timescale 1ns/1ns
module irport_ctrl_checker
	import irport_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic TX_DATA,
	input wire logic TX_FIFO_LEVEL_OK,
	input wire logic TX_TIMEOUT,
	input wire logic FIFO_32,
	input wire logic RX_LEN_OVER,
	input wire logic RX_BAD_SYMBOL,
	input wire logic BAUD_CLK,
	input wire logic UART_IRQ,
	input wire logic DTR_BIT,
	input wire logic DTR_PIN,
	input wire logic IRQ_OUT,
	input wire logic RX_LINE,
	input wire logic LOOPBACK,
	input wire logic TX_GO,
	input wire logic RX_STORE_EN,
	input wire logic RX_ABORT,
	input wire logic FRAME_END,
	input wire logic [5:0] TX_THRESHOLD,
	input wire logic [5:0] RX_THRESHOLD,
	input wire logic ADVANCED,
	input wire logic [2:0] MODE
);
	// Frame error handling only applies in the fast link modes
	logic fast_link;
	assign fast_link = ADVANCED && (MODE == MODE_MIR_LOW || MODE == MODE_MIR_HIGH ||
		MODE == MODE_FIR);
	// ****
	// Checks
	// ****
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	a_thr_low: assert property (RX_THRESHOLD == RX_THR_LOW |->
		TX_THRESHOLD == TX_THR_LOW) else $error("low thresholds wrong");
	a_thr_high: assert property (RX_THRESHOLD == RX_THR_HIGH |->
		TX_THRESHOLD == (FIFO_32 ? TX_THR_HIGH32 : TX_THR_HIGH16)) else $error("high thr wrong");
	a_irq_cause: assert property (IRQ_OUT |-> $past(UART_IRQ)) else $error("irq no cause");
	a_loop_line: assert property (LOOPBACK |-> RX_LINE == TX_DATA) else $error("loop rx");
	a_txwait_go: assert property (!TX_GO |-> !TX_FIFO_LEVEL_OK && !TX_TIMEOUT)
		else $error("tx held");
	a_len_stop: assert property (fast_link && RX_LEN_OVER |-> !RX_STORE_EN)
		else $error("store on");
	a_bad_symbol: assert property (fast_link && RX_BAD_SYMBOL |-> RX_ABORT && FRAME_END)
		else $error("no abort");
	a_baud_dtr: assert property (DTR_PIN |-> $past(BAUD_CLK) || $past(DTR_BIT))
		else $error("dtr no cause");
endmodule : irport_ctrl_checker

bind irport_ctrl irport_ctrl_checker irport_ctrl_checker_i (.SYS_CLK, .RESET, .TX_DATA,
	.TX_FIFO_LEVEL_OK, .TX_TIMEOUT, .FIFO_32, .RX_LEN_OVER, .RX_BAD_SYMBOL, .BAUD_CLK, .UART_IRQ,
	.DTR_BIT, .DTR_PIN, .IRQ_OUT, .RX_LINE, .LOOPBACK, .TX_GO, .RX_STORE_EN, .RX_ABORT,
	.FRAME_END, .TX_THRESHOLD, .RX_THRESHOLD, .ADVANCED, .MODE);

// ==== irport_partner.sv ====
`timescale 1ns/1ns
module irport_partner #(
	parameter int LAT = 2
) (
	input wire logic clk,
	input wire logic light,
	output logic IR_RX_PIN
);
	// ****
	// Transceiver delay, idle line high
	// ****
	logic [LAT-1:0] dly_q = '1;
	always_ff @(posedge clk) begin
		dly_q <= {dly_q[LAT-2:0], light};
	end
	assign IR_RX_PIN = dly_q[LAT-1];
endmodule : irport_partner

// ==== irport_ctrl_tb.sv ====
`timescale 1ns/1ns
module irport_ctrl_tb;
	import irport_pkg::*;
	logic SYS_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic PREADY, PSLVERR, IR_RX_PIN, DTR_PIN, IRQ_OUT, RX_LINE, LOOPBACK, TX_GO, RX_STORE_EN;
	logic RX_ABORT, FRAME_END, TX_TERM_COUNT, DMA_ENABLE, DMA_SERVES_TX, ADVANCED, IR_TX_PIN;
	logic [5:0] TX_THRESHOLD, RX_THRESHOLD;
	logic [15:0] DIVISOR;
	logic [2:0] MODE;
	logic TX_DATA = 0, TX_EMPTY = 0, TX_FIFO_LEVEL_OK = 0, TX_TIMEOUT = 0, DMA_TC = 0, FIFO_32 = 0;
	logic RX_FRAME_LAST = 0, RX_LEN_OVER = 0, RX_BAD_SYMBOL = 0, RX_CRC_BAD = 0, RX_END_LOST = 0;
	logic RX_REMOTE_PULSE = 0, RX_MARKERS_STORED = 0, RX_DATA_TIMEOUT = 0, RX_STATUS_TIMEOUT = 0;
	logic FLOW_SWITCH = 0, RX_BUSY = 0, BAUD_CLK = 0, UART_IRQ = 0, DTR_BIT = 0, light = 1;
	logic [5:0] TX_DEPTH = 6'h2A, RX_DEPTH = 6'h15;
	logic [7:0] rd;
	logic [7:0] codes [6] = '{SEL_BANK2, SEL_BANK3, SEL_BANK4, SEL_BANK5, SEL_BANK6, SEL_BANK7};
	int n_fail = 0, checks = 0;
	always #2 SYS_CLK = ~SYS_CLK;
	irport_ctrl irport_ctrl_i (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .TX_DATA, .TX_EMPTY, .TX_FIFO_LEVEL_OK, .TX_TIMEOUT, .DMA_TC, .TX_DEPTH,
		.RX_DEPTH, .FIFO_32, .RX_FRAME_LAST, .RX_LEN_OVER, .RX_BAD_SYMBOL, .RX_CRC_BAD, .RX_END_LOST,
		.RX_REMOTE_PULSE, .RX_MARKERS_STORED, .RX_DATA_TIMEOUT, .RX_STATUS_TIMEOUT, .FLOW_SWITCH,
		.RX_BUSY, .BAUD_CLK, .UART_IRQ, .IR_RX_PIN, .DTR_BIT, .IR_TX_PIN, .DTR_PIN, .IRQ_OUT,
		.RX_LINE, .LOOPBACK, .TX_GO, .RX_STORE_EN, .RX_ABORT, .FRAME_END, .TX_TERM_COUNT,
		.DMA_ENABLE, .DMA_SERVES_TX, .TX_THRESHOLD, .RX_THRESHOLD, .DIVISOR, .ADVANCED, .MODE);
	irport_partner #(.LAT(2)) irport_partner_i (.clk(SYS_CLK), .light, .IR_RX_PIN);
	// ****
	// Tasks
	// ****
	task automatic give_verdict();
		if (n_fail == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t check %0d got %h exp %h", $time, checks, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [2:0] idx, input logic [7:0] d);
		int n;
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= {3'h0, idx, 2'h0};
		PWDATA <= {24'h0, d};
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		rd = PRDATA[7:0];
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			give_verdict();
		end
	endtask : xfer
	task automatic rc(input logic [2:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask : rc
	// Settle past the edge so registered outputs have landed
	task automatic wt(input int k);
		repeat (k) @(posedge SYS_CLK);
		#1;
	endtask : wt
	// ****
	// Sequence
	// ****
	initial begin
		repeat (8) @(posedge SYS_CLK);
		RESET <= 1'b0;
		wt(1);
		chk({TX_THRESHOLD, RX_THRESHOLD}, {TX_THR_LOW, RX_THR_LOW});
		rc(REG_BANK_SEL, 8'hE0);
		chk({PREADY, PSLVERR}, 2'b10);
		rc(REG_CTRL_ONE, CTRL_ONE_RESET);
		rc(REG_DEPTH_TX, {2'b00, TX_DEPTH});
		rc(REG_USER_STATUS, {2'b00, RX_DEPTH});
		foreach (codes[k]) begin
			xfer(1'b1, REG_BANK_SEL, codes[k]);
			rc(REG_BANK_SEL, codes[k]);
		end
		xfer(1'b1, REG_BANK_SEL, 8'hFF);
		rc(REG_BANK_SEL, 8'h00);
		xfer(1'b1, REG_DIV_LOW, 8'h34);
		xfer(1'b1, REG_DIV_HIGH, 8'h12);
		wt(1);
		chk(DIVISOR, 16'h1234);
		xfer(1'b1, REG_BANK_SEL, 8'h7F);
		rc(REG_HANDSHAKE, HANDSHAKE_RESET);
		@(posedge SYS_CLK) light <= 1'b0;
		xfer(1'b1, REG_HANDSHAKE, 8'h18);
		@(posedge SYS_CLK) TX_DATA <= 1'b1;
		wt(4);
		chk({LOOPBACK, RX_LINE, IR_TX_PIN}, 3'b110);
		@(posedge SYS_CLK) UART_IRQ <= 1'b1;
		wt(2);
		chk(IRQ_OUT, 1'b1);
		xfer(1'b1, REG_HANDSHAKE, 8'h00);
		wt(2);
		chk({IRQ_OUT, LOOPBACK, RX_LINE}, 3'b000);
		xfer(1'b1, REG_BANK_SEL, SEL_BANK2);
		xfer(1'b1, REG_CTRL_ONE, 8'h0D);
		wt(1);
		chk({ADVANCED, DMA_SERVES_TX, TX_THRESHOLD}, {2'b11, TX_THR_HIGH16});
		@(posedge SYS_CLK) FIFO_32 <= 1'b1;
		wt(1);
		chk({RX_THRESHOLD, TX_THRESHOLD}, {RX_THR_HIGH, TX_THR_HIGH32});
		xfer(1'b1, REG_BANK_SEL, 8'h00);
		for (int m = 1; m < 7; m++) begin
			xfer(1'b1, REG_HANDSHAKE, {m[2:0], 5'h00});
			wt(1);
			chk(MODE, m[2:0]);
		end
		xfer(1'b1, REG_HANDSHAKE, 8'hAC);
		wt(1);
		chk({TX_GO, DMA_ENABLE}, 2'b01);
		@(posedge SYS_CLK) begin
			TX_TIMEOUT <= 1'b1;
			RX_LEN_OVER <= 1'b1;
			RX_BAD_SYMBOL <= 1'b1;
			RX_CRC_BAD <= 1'b1;
			RX_FRAME_LAST <= 1'b1;
			TX_EMPTY <= 1'b1;
			DMA_TC <= 1'b1;
		end
		wt(1);
		chk({TX_GO, RX_STORE_EN, RX_ABORT, FRAME_END}, 4'hB);
		@(posedge SYS_CLK) begin
			TX_TIMEOUT <= 1'b0;
			RX_LEN_OVER <= 1'b0;
			RX_BAD_SYMBOL <= 1'b0;
			RX_CRC_BAD <= 1'b0;
			TX_EMPTY <= 1'b0;
		end
		rc(REG_LINE_STATUS, 8'h9C);
		rc(REG_LINE_STATUS, 8'h80);
		rc(REG_USER_STATUS, 8'h00);
		xfer(1'b1, REG_HANDSHAKE, 8'hA0);
		@(posedge SYS_CLK) begin
			FLOW_SWITCH <= 1'b1;
			RX_END_LOST <= 1'b1;
			TX_EMPTY <= 1'b1;
			RX_MARKERS_STORED <= 1'b1;
			RX_STATUS_TIMEOUT <= 1'b1;
		end
		@(posedge SYS_CLK) begin
			FLOW_SWITCH <= 1'b0;
			RX_END_LOST <= 1'b0;
			TX_EMPTY <= 1'b0;
		end
		rc(REG_USER_STATUS, 8'hD3);
		rc(REG_USER_STATUS, 8'h43);
		xfer(1'b1, REG_USER_STATUS, 8'h40);
		@(posedge SYS_CLK) begin
			RX_STATUS_TIMEOUT <= 1'b0;
			RX_DATA_TIMEOUT <= 1'b1;
			RX_MARKERS_STORED <= 1'b0;
		end
		rc(REG_USER_STATUS, 8'h01);
		xfer(1'b1, REG_USER_STATUS, 8'h08);
		wt(1);
		chk(TX_TERM_COUNT, 1'b1);
		xfer(1'b1, REG_HANDSHAKE, 8'hC0);
		@(posedge SYS_CLK) RX_REMOTE_PULSE <= 1'b1;
		@(posedge SYS_CLK) RX_REMOTE_PULSE <= 1'b0;
		xfer(1'b0, REG_USER_STATUS, 8'h00);
		chk(rd[4], 1'b1);
		xfer(1'b1, REG_BANK_SEL, SEL_BANK2);
		xfer(1'b1, REG_CTRL_ONE, 8'hB1);
		@(posedge SYS_CLK) BAUD_CLK <= 1'b1;
		wt(2);
		chk({DTR_PIN, LOOPBACK, IR_TX_PIN}, 3'b111);
		@(posedge SYS_CLK) begin
			BAUD_CLK <= 1'b0;
			TX_DATA <= 1'b0;
		end
		wt(2);
		chk({DTR_PIN, IR_TX_PIN}, 2'b00);
		xfer(1'b1, REG_BANK_SEL, 8'h80);
		xfer(1'b0, REG_DIV_LOW, 8'h00);
		wt(1);
		chk({ADVANCED, MODE}, 4'h0);
		rc(REG_HANDSHAKE, 8'h00);
		xfer(1'b1, REG_BANK_SEL, SEL_BANK2);
		rc(REG_CTRL_ONE, 8'h10);
		xfer(1'b1, REG_HANDSHAKE, 8'h80);
		xfer(1'b1, REG_CTRL_ONE, 8'h01);
		xfer(1'b1, REG_BANK_SEL, 8'h80);
		xfer(1'b1, REG_DIV_HIGH, 8'h00);
		wt(1);
		chk(ADVANCED, 1'b1);
		chk(DIVISOR, 16'h0001);
		xfer(1'b1, REG_HANDSHAKE, 8'hB0);
		@(posedge SYS_CLK) TX_EMPTY <= 1'b1;
		wt(2);
		chk(IR_TX_PIN, 1'b1);
		rc(REG_HANDSHAKE, 8'hA0);
		give_verdict();
	end
endmodule : irport_ctrl_tb
